//--- sixteen_bit_timer_three_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sixteen_bit_timer_three_bench
	import tmt_pkg::*;
;
	localparam logic [7:0] RCTL [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
	localparam logic [1:0] RSEL [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
	logic        hclk     = 1'b0;
	logic        hresetn  = 1'b0;
	logic        hsel     = 1'b0;
	logic [7:0]  haddr    = 8'h00;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0000_0000;
	logic [15:0] t1_cnt   = 16'h0000;
	logic [15:0] ch1_val  = 16'h0000;
	logic [3:0]  ch1_mode = 4'h0;
	logic [15:0] ch2_val  = 16'h0000;
	logic [3:0]  ch2_mode = 4'h0;
	logic [1:0]  pdir     = 2'h0;
	logic [7:0]  v;
	logic [7:0]  lo;
	wire         hready;
	wire         hresp;
	wire         ext_clk;
	wire         osc_en;
	wire         irq;
	wire         irq_hp;
	wire  [31:0] hrdata;
	wire  [1:0]  osc_dir;
	wire  [15:0] tb1;
	wire  [15:0] tb2;
	int          n_errors  = 0;
	int          tests_run = 0;

	always #5 hclk = ~hclk;

	tmt_ext_src ext (.hclk(hclk), .ext_clk(ext_clk));

	tmt_top dut (
		.hclk                 (hclk),
		.hresetn              (hresetn),
		.hsel                 (hsel),
		.haddr                (haddr),
		.htrans               (htrans),
		.hwrite               (hwrite),
		.hsize                (3'h2),
		.hwdata               (hwdata),
		.hready               (hready),
		.hreadyout            (hready),
		.hresp                (hresp),
		.hrdata               (hrdata),
		.ext_count_in         (ext_clk),
		.timer1_count         (t1_cnt),
		.ch1_value            (ch1_val),
		.ch2_value            (ch2_val),
		.ch1_mode_code        (ch1_mode),
		.ch2_mode_code        (ch2_mode),
		.port_direction       (pdir),
		.osc_pin_dir          (osc_dir),
		.low_power_osc_enable (osc_en),
		.ch1_timebase         (tb1),
		.ch2_timebase         (tb2),
		.irq                  (irq),
		.irq_high_priority    (irq_hp)
	);

	// hready and hrdata are read at the rising edge, before that edge's updates land
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
		r = hrdata[7:0];
		`CHK("response", 1'b0, hresp)
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00, v);
		`CHK(nm, e, v)
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		$display("unexpected watchdog expected done seen timeout");
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_reg("ctl3", OFS_CTL_T3, CTL_T3_RESET);
		chk_reg("ctl1", OFS_CTL_T1, CTL_T1_RESET);
		chk_reg("flags", OFS_FLAGS, IRQ_REG_RESET);
		chk_reg("unmapped", 8'h1C, 8'h00);
		$display("test reset done");
		wr(OFS_COUNT_LO, 8'h34);
		wr(OFS_COUNT_HI, 8'h12);
		repeat (40) @(posedge hclk);
		chk_reg("count lo", OFS_COUNT_LO, 8'h34);
		chk_reg("count hi", OFS_COUNT_HI, 8'h12);
		wr(OFS_CTL_T3, 8'h80);
		wr(OFS_COUNT_HI, 8'hAB);
		chk_reg("count lo", OFS_COUNT_LO, 8'h34);
		chk_reg("hi buffer", OFS_COUNT_HI, 8'h12);
		wr(OFS_COUNT_HI, 8'hAB);
		wr(OFS_COUNT_LO, 8'hCD);
		wr(OFS_CTL_T3, 8'h00);
		chk_reg("count hi", OFS_COUNT_HI, 8'hAB);
		chk_reg("count lo", OFS_COUNT_LO, 8'hCD);
		$display("test byte access done");
		for (int p = 0; p < 4; p++) begin
			wr(OFS_COUNT_HI, 8'h00);
			wr(OFS_COUNT_LO, 8'h00);
			wr(OFS_CTL_T3, 8'(p << CTL_PRESC_LSB) | 8'h01);
			repeat (318) @(posedge hclk);
			wr(OFS_CTL_T3, 8'h00);
			xfer(1'b0, OFS_COUNT_LO, 8'h00, lo);
			`CHK("scaled count", 1'b1, lo >= 8'(79 >> p) && lo <= 8'(81 >> p))
		end
		$display("test prescale done");
		for (int s = 0; s < 2; s++) begin
			wr(OFS_COUNT_LO, 8'h00);
			wr(OFS_CTL_T3, 8'h03 | 8'(s << CTL_SYNCBYP_BIT));
			ext.burst(5, 4);
			repeat (8) @(posedge hclk);
			wr(OFS_CTL_T3, 8'h00);
			chk_reg("edge count", OFS_COUNT_LO, 8'h04);
		end
		$display("test external clock done");
		wr(OFS_COUNT_HI, 8'hFF);
		wr(OFS_COUNT_LO, 8'hF0);
		wr(OFS_CTL_T3, 8'h01);
		repeat (100) @(posedge hclk);
		wr(OFS_CTL_T3, 8'h00);
		chk_reg("flags", OFS_FLAGS, 8'h02);
		`CHK("masked irq", 1'b0, irq)
		chk_reg("count hi", OFS_COUNT_HI, 8'h00);
		wr(OFS_ENABLES, 8'h02);
		`CHK("irq", 1'b1, irq)
		wr(OFS_FLAGS, 8'h02);
		`CHK("irq", 1'b0, irq)
		chk_reg("flags", OFS_FLAGS, 8'h00);
		wr(OFS_PRIORITY, 8'h02);
		`CHK("priority", 1'b1, irq_hp)
		$display("test overflow done");
		t1_cnt <= 16'h1111;
		wr(OFS_COUNT_HI, 8'h22);
		wr(OFS_COUNT_LO, 8'h22);
		foreach (RCTL[i]) begin
			wr(OFS_CTL_T3, RCTL[i]);
			`CHK("ch1 base", RSEL[i][0] ? 16'h2222 : 16'h1111, tb1)
			`CHK("ch2 base", RSEL[i][1] ? 16'h2222 : 16'h1111, tb2)
		end
		wr(OFS_COUNT_HI, 8'h00);
		wr(OFS_COUNT_LO, 8'h00);
		ch1_val  <= 16'h0010;
		ch1_mode <= TRIGGER_MODE;
		// Internal timer mode so the trigger reset is dependable
		wr(OFS_CTL_T3, 8'h41);
		repeat (300) @(posedge hclk);
		wr(OFS_CTL_T3, 8'h00);
		ch1_mode <= 4'h0;
		xfer(1'b0, OFS_COUNT_LO, 8'h00, lo);
		`CHK("period", 1'b1, lo <= 8'h10)
		chk_reg("count hi", OFS_COUNT_HI, 8'h00);
		chk_reg("flags", OFS_FLAGS, 8'h00);
		// Stopped counter parked on a channel 2 match: the trigger holds it at zero
		ch2_mode <= TRIGGER_MODE;
		wr(OFS_CTL_T3, 8'h08);
		wr(OFS_COUNT_LO, 8'h00);
		wr(OFS_COUNT_LO, 8'h55);
		chk_reg("write over trigger", OFS_COUNT_LO, 8'h55);
		ch2_val <= 16'h0055;
		repeat (2) @(posedge hclk);
		chk_reg("ch2 trigger", OFS_COUNT_LO, 8'h00);
		// Period at the top of the range: a missed trigger would wrap and flag
		ch2_val <= 16'hFFFF;
		wr(OFS_COUNT_HI, 8'hFF);
		wr(OFS_COUNT_LO, 8'hF0);
		wr(OFS_CTL_T3, 8'h09);
		repeat (100) @(posedge hclk);
		wr(OFS_CTL_T3, 8'h00);
		ch2_mode <= 4'h0;
		chk_reg("flags at top", OFS_FLAGS, 8'h00);
		$display("test trigger done");
		pdir <= 2'h1;
		wr(OFS_CTL_T1, 8'hFF);
		`CHK("osc dir", 2'h3, osc_dir)
		`CHK("osc en", 1'b1, osc_en)
		chk_reg("ctl1", OFS_CTL_T1, T1_IMPL_MASK);
		wr(OFS_CTL_T1, 8'h00);
		`CHK("osc dir", 2'h1, osc_dir)
		$display("test oscillator done");
		wr(OFS_CTL_T3, 8'hF5);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_reg("ctl3", OFS_CTL_T3, 8'h00);
		$display("test second reset done");
		print_verdict();
	end
endmodule

//--- tmt_ccp_if.sv
`timescale 1ns/1ps
interface tmt_ccp_if;
	logic [15:0] t3_count;
	logic [15:0] t1_count;
	logic [15:0] ch_value    [2];
	logic [3:0]  ch_mode     [2];
	logic        sel_hi;
	logic        sel_lo;
	logic [15:0] ch_timebase [2];
	logic        trig;
	modport timer (output t3_count, t1_count, ch_value, ch_mode, sel_hi, sel_lo,
	               input ch_timebase, trig);
	modport route (input t3_count, t1_count, ch_value, ch_mode, sel_hi, sel_lo,
	               output ch_timebase, trig);
endinterface

//--- tmt_ext_src.sv
`timescale 1ns/1ps
module tmt_ext_src (
	input  wire logic hclk,
	output logic      ext_clk
);
	// Gated source: rests low between bursts so no stray edge is counted
	initial ext_clk = 1'b0;
	task automatic burst(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge hclk);
			ext_clk <= 1'b1;
			repeat (half) @(posedge hclk);
			ext_clk <= 1'b0;
		end
	endtask
endmodule

//--- tmt_pkg.sv
package tmt_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_COUNT_LO = 8'h00;
	localparam logic [7:0] OFS_COUNT_HI = 8'h04;
	localparam logic [7:0] OFS_CTL_T3   = 8'h08;
	localparam logic [7:0] OFS_CTL_T1   = 8'h0C;
	localparam logic [7:0] OFS_FLAGS    = 8'h10;
	localparam logic [7:0] OFS_ENABLES  = 8'h14;
	localparam logic [7:0] OFS_PRIORITY = 8'h18;

	// Field positions of timer_three_control
	localparam int CTL_WIDE_BIT    = 7;
	localparam int CTL_SELHI_BIT   = 6;
	localparam int CTL_PRESC_LSB   = 4;
	localparam int CTL_SELLO_BIT   = 3;
	localparam int CTL_SYNCBYP_BIT = 2;
	localparam int CTL_SRC_BIT     = 1;
	localparam int CTL_ON_BIT      = 0;
	// Field position in timer_one_control
	localparam int T1_OSC_EN_BIT   = 3;
	localparam logic [7:0] T1_IMPL_MASK = 8'hBF;
	// Overflow bit in flags, enables and priority registers
	localparam int OVF_BIT         = 1;

	localparam logic [7:0] CTL_T3_RESET = 8'h00;
	localparam logic [7:0] CTL_T1_RESET = 8'h00;
	localparam logic [7:0] IRQ_REG_RESET = 8'h00;

	localparam logic [3:0]  TRIGGER_MODE = 4'b1011;
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	// System clocks per instruction cycle
	localparam int INSTR_DIV = 4;
endpackage

//--- tmt_route.sv
`timescale 1ns/1ps
module tmt_route
	import tmt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	tmt_ccp_if.route bus
);
	function automatic logic is_trigger(input logic [3:0] mode);
		return mode == TRIGGER_MODE;
	endfunction

	logic [1:0] uses_t3;
	logic [1:0] hit;

	assign uses_t3[0] = bus.sel_hi;                // [RQ2]
	assign uses_t3[1] = bus.sel_hi | bus.sel_lo;   // [RQ2]

	for (genvar i = 0; i < 2; i++) begin : g_ch
		assign bus.ch_timebase[i] = uses_t3[i] ? bus.t3_count : bus.t1_count;
		// A match on the channel value returns the count to zero, so that value
		// behaves as the period of this timer
		assign hit[i] = is_trigger(bus.ch_mode[i]) & uses_t3[i]
		                & (bus.t3_count == bus.ch_value[i]); // [RQ10] [RQ13]
	end
	assign bus.trig = |hit;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_route_ch2: assert property (bus.sel_lo && !bus.sel_hi |-> // [RQ2]
		bus.ch_timebase[1] == bus.t3_count && bus.ch_timebase[0] == bus.t1_count)
		else $error("channel time base routing wrong");
endmodule

//--- tmt_top.sv
`timescale 1ns/1ps
// Contract
// (RQ1) Control bit 7 set gives atomic 16-bit counter access, clear gives bytes.
// (RQ2) Routing bits 6,3: 1x both Timer3; 01 channel 2 Timer3; 00 both Timer1.
// (RQ3) Prescale bits 5-4 divide counting clock by 1, 2, 4, 8.
// (RQ4) External clock: bit 2 set bypasses synchroniser; ignored for internal clock.
// (RQ5) Source bit 1: clear counts instruction cycles, set counts external rising edges.
// (RQ6) Control bit 0 enables counting; clear holds the count.
// (RQ7) Power-on reset clears control register; other resets leave it unchanged. Here every hresetn assertion clears it.
// (RQ8) Oscillator enable forces both oscillator pins to inputs.
// (RQ9) Count wraps FFFFh to 0000h, setting overflow flag; interrupt only when enabled.
// (RQ10) Channel in trigger compare mode matching resets the count to zero.
// (RQ11) A trigger reset never sets the overflow flag.
// (RQ12) Counter write in the same cycle as trigger wins over the reset.
// (RQ13) Compare value acts as the timer period under trigger reset.
// (RQ14) Software uses timer or synchronised counting when relying on trigger reset.
// (RQ15) Both count bytes are readable and writable in all modes.
// (RQ16) Wide mode: low read latches high byte; high write buffered until low write.
// (RQ17) Only a low byte write clears the prescaler.
// (RQ18) Overflow flag stays set until software clears it.
module tmt_top
	import tmt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              ext_count_in,
	input  wire logic [15:0]       timer1_count,
	input  wire logic [15:0]       ch1_value,
	input  wire logic [15:0]       ch2_value,
	input  wire logic [3:0]        ch1_mode_code,
	input  wire logic [3:0]        ch2_mode_code,
	input  wire logic [1:0]        port_direction,
	output logic [1:0]             osc_pin_dir,
	output logic                   low_power_osc_enable,
	output logic [15:0]            ch1_timebase,
	output logic [15:0]            ch2_timebase,
	output logic                   irq,
	output logic                   irq_high_priority
);
	// Refused while the design is built, before any clock runs
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must hold the register map");
	end
	if (INSTR_DIV < 2) begin : g_bad_div
		$error("INSTR_DIV must be at least 2");
	end

	localparam int DIV_W = $clog2(INSTR_DIV);

	// Bus slave state
	logic              act_r;
	logic              wr_r;
	logic [7:0]        addr_r;
	logic [31:0]       rdata_r;
	// Software registers
	logic [7:0]        ctl_r;
	logic [7:0]        t1ctl_r;
	logic [7:0]        flags_r;
	logic [7:0]        enables_r;
	logic [7:0]        prio_r;
	// Timer core
	logic [15:0]       count_r;
	logic [15:0]       count_nxt;
	logic [7:0]        hibuf_r;
	logic [2:0]        presc_r;
	logic [DIV_W-1:0]  div_r;
	logic              sync1_r;
	logic              sync2_r;
	logic              ext_prev_r;
	logic              armed_r;

	tmt_ccp_if ccp ();

	tmt_route u_route (
		.hclk    (hclk),
		.hresetn (hresetn),
		.bus     (ccp)
	);

	assign ccp.t3_count    = count_r;
	assign ccp.t1_count    = timer1_count;
	assign ccp.ch_value[0] = ch1_value;
	assign ccp.ch_value[1] = ch2_value;
	assign ccp.ch_mode[0]  = ch1_mode_code;
	assign ccp.ch_mode[1]  = ch2_mode_code;
	assign ccp.sel_hi      = ctl_r[CTL_SELHI_BIT];
	assign ccp.sel_lo      = ctl_r[CTL_SELLO_BIT];
	assign ch1_timebase    = ccp.ch_timebase[0];
	assign ch2_timebase    = ccp.ch_timebase[1];

	// Bus decode: every transfer takes one wait state so read data leave a flop
	wire       accept   = hsel & hready & htrans[1];
	wire       wr_en    = act_r & wr_r;
	wire       rd_en    = act_r & ~wr_r;
	wire       sel_lo   = addr_r == OFS_COUNT_LO;
	wire       sel_hi   = addr_r == OFS_COUNT_HI;
	wire       wide     = ctl_r[CTL_WIDE_BIT];
	wire       wr_low   = wr_en & sel_lo;
	wire       wr_high  = wr_en & sel_hi;
	wire       wr_hi_nr = wr_high & ~wide;
	wire       rd_low   = rd_en & sel_lo;
	wire [7:0] wbyte    = hwdata[7:0];

	assign hreadyout = ~act_r;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;

	// Clock selection and edge qualification
	wire       on        = ctl_r[CTL_ON_BIT];
	wire       ext_src   = ctl_r[CTL_SRC_BIT];
	wire [1:0] presc_sel = ctl_r[CTL_PRESC_LSB +: 2];
	// The bypass is only chosen where the edge is already clean; a trigger reset
	// against an unsynchronised clock may be missed, hence software avoids it
	wire       ext_lvl   = ctl_r[CTL_SYNCBYP_BIT] ? ext_count_in : sync2_r; // [RQ4] [RQ14]
	wire       ext_rise  = ext_lvl & ~ext_prev_r & armed_r;                  // [RQ5]
	wire       ext_fall  = ~ext_lvl & ext_prev_r;
	wire       instr_tk  = div_r == DIV_W'(INSTR_DIV - 1);
	wire       src_tick  = ext_src ? ext_rise : instr_tk;                    // [RQ5]
	wire [2:0] presc_msk = 3'(({1'b0, 3'b000} | 4'((1 << presc_sel) - 1)));  // [RQ3]
	wire       presc_hit = (presc_r & presc_msk) == presc_msk;
	wire       step      = on & src_tick;                                    // [RQ6]
	wire       inc       = step & presc_hit;
	wire       trig      = ccp.trig;
	wire       wr_count  = wr_low | wr_hi_nr;
	wire       ovf_evt   = inc & (count_r == COUNT_MAX) & ~wr_count & ~trig; // [RQ9] [RQ11]

	always_comb begin
		count_nxt = count_r;
		if (wr_low) begin
			count_nxt = {wide ? hibuf_r : count_r[15:8], wbyte};     // [RQ15] [RQ16]
		end else if (wr_hi_nr) begin
			count_nxt = {wbyte, count_r[7:0]};                       // [RQ1] [RQ15]
		end else if (trig) begin
			count_nxt = 16'h0000;                                    // [RQ10] [RQ12]
		end else if (inc) begin
			count_nxt = count_r + 16'h0001;                          // [RQ9]
		end
	end

	// Read mux, unmapped addresses read zero
	logic [7:0] rd_byte;
	always_comb begin
		unique case (addr_r)
			OFS_COUNT_LO: rd_byte = count_r[7:0];
			OFS_COUNT_HI: rd_byte = wide ? hibuf_r : count_r[15:8];   // [RQ1] [RQ16]
			OFS_CTL_T3:   rd_byte = ctl_r;
			OFS_CTL_T1:   rd_byte = t1ctl_r;
			OFS_FLAGS:    rd_byte = flags_r;
			OFS_ENABLES:  rd_byte = enables_r;
			OFS_PRIORITY: rd_byte = prio_r;
			default:      rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_r   <= 1'b0;
			wr_r    <= 1'b0;
			addr_r  <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else begin
			act_r <= accept;
			if (accept) begin
				wr_r   <= hwrite;
				addr_r <= 8'(haddr) & 8'hFC;
			end
			if (rd_en) begin
				rdata_r <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Every hresetn assertion clears the control register, at power-on and later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_r     <= CTL_T3_RESET;                               // [RQ7]
			t1ctl_r   <= CTL_T1_RESET;
			enables_r <= IRQ_REG_RESET;
			prio_r    <= IRQ_REG_RESET;
		end else if (wr_en) begin
			if (addr_r == OFS_CTL_T3) begin
				ctl_r <= wbyte;
			end
			if (addr_r == OFS_CTL_T1) begin
				t1ctl_r <= wbyte & T1_IMPL_MASK;
			end
			if (addr_r == OFS_ENABLES) begin
				enables_r <= wbyte & (8'h01 << OVF_BIT);
			end
			if (addr_r == OFS_PRIORITY) begin
				prio_r <= wbyte & (8'h01 << OVF_BIT);
			end
		end
	end

	// Set beats a same-cycle write-one clear
	wire [7:0] ovf_set = {7'h00, ovf_evt} << OVF_BIT;
	wire [7:0] ovf_clr = (wr_en && addr_r == OFS_FLAGS) ? wbyte : 8'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_r <= IRQ_REG_RESET;
		end else begin
			flags_r <= (flags_r & ~ovf_clr) | ovf_set;               // [RQ18]
		end
	end

	assign irq = |(flags_r & enables_r);                             // [RQ9]
	assign irq_high_priority = prio_r[OVF_BIT];

	assign low_power_osc_enable = t1ctl_r[T1_OSC_EN_BIT];
	// A one marks an input
	assign osc_pin_dir = low_power_osc_enable ? 2'b11 : port_direction; // [RQ8]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= 16'h0000;
			hibuf_r <= 8'h00;
		end else begin
			count_r <= count_nxt;
			if (rd_low && wide) begin
				hibuf_r <= count_r[15:8];                            // [RQ16]
			end else if (wr_high && wide) begin
				hibuf_r <= wbyte;                                    // [RQ16]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_r <= 3'b000;
		end else if (wr_low) begin
			presc_r <= 3'b000;                                       // [RQ17]
		end else if (step) begin
			presc_r <= presc_hit ? 3'b000 : presc_r + 3'b001;        // [RQ3]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= '0;
		end else begin
			div_r <= instr_tk ? '0 : div_r + DIV_W'(1);
		end
	end

	// Edges count only after a falling edge has been seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r    <= 1'b0;
			sync2_r    <= 1'b0;
			ext_prev_r <= 1'b0;
			armed_r    <= 1'b0;
		end else begin
			sync1_r    <= ext_count_in;
			sync2_r    <= sync1_r;
			ext_prev_r <= ext_lvl;
			if (!ext_src) begin
				armed_r <= 1'b0;
			end else if (ext_fall) begin
				armed_r <= 1'b1;                                     // [RQ5]
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_trig_clears: assert property (trig && !wr_count |=> count_r == 16'h0000) // [RQ10]
		else $error("trigger did not clear the count");
	chk_trig_no_flag: assert property (trig && !flags_r[OVF_BIT] |=> // [RQ11]
		!flags_r[OVF_BIT])
		else $error("trigger reset set the overflow flag");
	chk_write_wins: assert property (wr_low && trig |=> // [RQ12]
		count_r[7:0] == $past(hwdata[7:0]))
		else $error("trigger overrode a counter write");
	chk_wrap_flag: assert property (ovf_evt |=> count_r == 16'h0000 // [RQ9]
		&& flags_r[OVF_BIT])
		else $error("wrap did not set overflow flag");
	chk_flag_sticky: assert property (flags_r[OVF_BIT] && !ovf_clr[OVF_BIT] |=> // [RQ18]
		flags_r[OVF_BIT])
		else $error("overflow flag dropped without clear");
	chk_stop_hold: assert property (!on && !wr_count && !trig |=> // [RQ6]
		count_r == $past(count_r))
		else $error("stopped counter changed");
	chk_low_presc: assert property (wr_low |=> presc_r == 3'b000) // [RQ17]
		else $error("low write left prescaler running");
	chk_hibuf_latch: assert property (rd_low && wide |=> // [RQ16]
		hibuf_r == $past(count_r[15:8]))
		else $error("high byte not latched on low read");
	chk_instr_rate: assert property (inc && !ext_src |=> !inc [*3]) // [RQ5]
		else $error("internal clock counted faster than instruction rate");
	chk_osc_inputs: assert property (t1ctl_r[T1_OSC_EN_BIT] |-> osc_pin_dir == 2'b11) // [RQ8]
		else $error("oscillator pins not forced to inputs");
endmodule
